// ### asrb_pkg.sv
`default_nettype none
package asrb_pkg;
	localparam int unsigned AW                = 5;
	localparam int unsigned DW                = 8;
	// Register offsets
	localparam logic [4:0]  ADDR_THR_POS      = 5'h10;
	localparam logic [4:0]  ADDR_THR_NEG      = 5'h12;
	localparam logic [4:0]  ADDR_STATUS       = 5'h14;
	localparam logic [4:0]  ADDR_COUNT        = 5'h15;
	localparam logic [4:0]  ADDR_OFFCORR      = 5'h16;
	localparam logic [4:0]  ADDR_RSVD_A       = 5'h1C;
	localparam logic [4:0]  ADDR_RSVD_B       = 5'h1D;
	// Reset values
	localparam logic [7:0]  THR_RESET         = 8'h00;
	localparam logic [7:0]  COUNT_RESET       = 8'h00;
	localparam logic [7:0]  OFFCORR_RESET     = 8'h00;
	localparam logic [7:0]  ZERO_BYTE         = 8'h00;
	localparam logic [1:0]  MODE_OFF          = 2'h0;
	// CRC: generator x^3+x+1, seed all ones
	localparam logic [2:0]  CRC_SEED          = 3'h7;
	localparam logic [2:0]  CRC_POLY          = 3'h3;
	// Timing
	localparam int unsigned CLK_PERIOD_NS     = 50;
	localparam int unsigned TICK_PERIOD_NS    = 128000;
	localparam int unsigned TICK_CYCLES       = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned PRE_W             = 12;
	localparam logic [11:0] PRE_LAST          = 12'(TICK_CYCLES - 1);

	typedef struct packed {
		logic unused;
		logic internal_data_error_flag;
		logic modulator_overrange_flag;
		logic initializing_flag;
		logic serial_out_mismatch_flag;
		logic zero;
		logic offset;
		logic reset_occurred_flag;
	} asrb_stat_type;

	typedef struct packed {
		logic otp_crc;
		logic int_fault;
		logic modulator_overrange_flag;
		logic serial_out_mismatch_flag;
		logic offset;
	} asrb_fault_type;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [4:0] addr;
		logic [7:0] wdata;
	} asrb_acc_type;
endpackage : asrb_pkg
`default_nettype wire

// ### asrb_crc3.sv
`default_nettype none
module asrb_crc3
	import asrb_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	// Checked data
	input  wire logic        closed_i,
	input  wire logic [15:0] data_i,
	// Sticky mismatch
	output logic             err_o
);
	function automatic logic [2:0] crc3(input logic [15:0] d);
		logic [2:0] c;
		logic       fb;
		c = CRC_SEED;
		for (int i = 15; i >= 0; i--) begin
			fb = c[2] ^ d[i];
			c  = {c[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
		end
		return c;
	endfunction : crc3

	logic [2:0] ref_q,   ref_d;
	logic       armed_q, armed_d;
	logic       err_q,   err_d;

	// Reference taken as the lock closes; registers cannot change after that
	always_comb begin
		ref_d   = ref_q;
		armed_d = armed_q;
		err_d   = err_q;
		if (closed_i && !armed_q) begin
			ref_d   = crc3(data_i);
			armed_d = 1'b1;
		end
		if (armed_q && (crc3(data_i) != ref_q)) begin
			err_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_q   <= CRC_SEED;
			armed_q <= 1'b0;
			err_q   <= 1'b0;
		end else if (ce_i) begin
			ref_q   <= ref_d;
			armed_q <= armed_d;
			err_q   <= err_d;
		end
	end

	assign err_o = err_q;
endmodule : asrb_crc3
`default_nettype wire

// ### asrb_tick_cnt.sv
`default_nettype none
module asrb_tick_cnt
	import asrb_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	// Count value
	output logic [7:0]      cnt_o
);
	logic [PRE_W-1:0] pre_q, pre_d;
	logic [7:0]       cnt_q, cnt_d;

	always_comb begin
		pre_d = pre_q + 12'h001;
		cnt_d = cnt_q;
		if (pre_q == PRE_LAST) begin
			pre_d = 12'h000;
			cnt_d = cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_q <= 12'h000;
			cnt_q <= COUNT_RESET;
		end else if (ce_i) begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
		end
	end

	assign cnt_o = cnt_q;
endmodule : asrb_tick_cnt
`default_nettype wire

// ### asrb_top.sv
`default_nettype none
// Contract
// RL1 - Threshold writes accepted only before the end-of-init lock closes.
// RL2 - Both thresholds are covered by the writable-register CRC check.
// RL3 - Each threshold is an independent unsigned 8-bit value, one output LSB per count.
// RL4 - A zero threshold disables only its own polarity; the other stays armed.
// RL5 - Both thresholds zero disables arming and its pin regardless of mode.
// RL6 - Status is read-only; a read clears all transient flags.
// RL7 - The unused status bit carries no meaning; the master ignores it.
// RL8 - Internal data error set on CRC or internal fault, cleared by status read.
// RL9 - Persistent faults re-assert the error flag after a clearing read.
// RL10 - Modulator over-range sets its flag; status read clears it.
// RL11 - Initializing flag set from reset release until init completes; reads leave it.
// RL12 - Serial output mismatch sets its flag; status read clears it.
// RL13 - Offset limit reached sets its flag; status read clears it.
// RL14 - Reset-occurred flag set during post-reset init, cleared by status read.
// RL15 - Read-only free-running 8-bit counter stepping every 128 us.
// RL16 - Offset correction readback shows the latest applied step, read-only.
// RL17 - The master writes only zeros to the two reserved registers.
// RL18 - After lock, writable registers are CRC checked; mismatch sets the error flag.
// RL19 - Writes to status, counter and offset readback are ignored.
module asrb_top
	import asrb_pkg::*;
(
	// Clock, reset, enable
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       ce_i,
	// Register access port
	input  wire logic       acc_rd_i,
	input  wire logic       acc_wr_i,
	input  wire logic [4:0] acc_addr_i,
	input  wire logic [7:0] acc_wdata_i,
	output logic      [7:0] rdata_o,
	// Neighbouring units
	input  wire logic       init_closed_bit_i,
	input  wire logic       init_done_i,
	input  wire logic [1:0] arm_mode_i,
	input  wire logic       otp_crc_err_i,
	input  wire logic       int_fault_i,
	input  wire logic       modulator_overrange_flag_i,
	input  wire logic       serial_out_mismatch_flag_i,
	input  wire logic       offset_lim_i,
	input  wire logic       offcorr_stb_i,
	input  wire logic [7:0] offcorr_i,
	// Arming controls
	output logic      [7:0] thr_pos_o,
	output logic      [7:0] thr_neg_o,
	output logic            pos_arm_en_o,
	output logic            neg_arm_en_o,
	output logic            arm_pin_en_o,
	output logic      [1:0] arm_mode_o
);
	logic [1:0]     rst_sync_q;
	logic           rst_n;
	asrb_acc_type   acc;
	asrb_fault_type flt;

	// Asynchronous assert, synchronous release
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	assign acc = '{rd: acc_rd_i, wr: acc_wr_i, addr: acc_addr_i, wdata: acc_wdata_i};
	assign flt = '{otp_crc: otp_crc_err_i, int_fault: int_fault_i, modulator_overrange_flag: modulator_overrange_flag_i,
		serial_out_mismatch_flag: serial_out_mismatch_flag_i, offset: offset_lim_i};

	// Threshold registers and arming controls
	logic [7:0] thr_p_q, thr_p_d;
	logic [7:0] thr_n_q, thr_n_d;
	logic       pos_en_q, pos_en_d;
	logic       neg_en_q, neg_en_d;
	logic       pin_en_q, pin_en_d;
	logic [1:0] mode_q,   mode_d;

	always_comb begin
		thr_p_d = thr_p_q;
		thr_n_d = thr_n_q;
		// Lock is sampled live so a write in the closing cycle is already refused
		if (acc.wr && !init_closed_bit_i) begin // [RL1]
			if (acc.addr == ADDR_THR_POS) begin
				thr_p_d = acc.wdata; // [RL3]
			end
			if (acc.addr == ADDR_THR_NEG) begin
				thr_n_d = acc.wdata; // [RL3]
			end
		end
		pos_en_d = (thr_p_d != ZERO_BYTE); // [RL4]
		neg_en_d = (thr_n_d != ZERO_BYTE); // [RL4]
		pin_en_d = pos_en_d || neg_en_d; // [RL5]
		mode_d   = pin_en_d ? arm_mode_i : MODE_OFF; // [RL5]
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			thr_p_q  <= THR_RESET;
			thr_n_q  <= THR_RESET;
			pos_en_q <= 1'b0;
			neg_en_q <= 1'b0;
			pin_en_q <= 1'b0;
			mode_q   <= MODE_OFF;
		end else if (ce_i) begin
			thr_p_q  <= thr_p_d;
			thr_n_q  <= thr_n_d;
			pos_en_q <= pos_en_d;
			neg_en_q <= neg_en_d;
			pin_en_q <= pin_en_d;
			mode_q   <= mode_d;
		end
	end

	// Writable-register CRC and oscillator counter
	logic       wcrc_err;
	logic [7:0] count;

	asrb_crc3 u_crc (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n),
		.ce_i     (ce_i),
		.closed_i (init_closed_bit_i),
		.data_i   ({thr_p_q, thr_n_q}), // [RL2]
		.err_o    (wcrc_err)
	);

	asrb_tick_cnt u_cnt (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.ce_i    (ce_i),
		.cnt_o   (count) // [RL15]
	);

	// Status flags; a set in the clearing cycle wins
	asrb_stat_type st_q, st_d;
	logic          st_rd;
	logic [7:0]    offc_q, offc_d;

	assign st_rd = acc.rd && (acc.addr == ADDR_STATUS); // [RL6]

	always_comb begin
		st_d         = st_q;
		st_d.unused  = 1'b0; // [RL7]
		st_d.zero    = 1'b0;
		if (st_rd) begin // [RL6]
			st_d.internal_data_error_flag     = 1'b0;
			st_d.modulator_overrange_flag    = 1'b0;
			st_d.serial_out_mismatch_flag = 1'b0;
			st_d.offset  = 1'b0;
			st_d.reset_occurred_flag  = 1'b0;
		end
		// Level sources re-assert at once, so persistent faults survive the read
		if (wcrc_err || flt.otp_crc || flt.int_fault) begin // [RL8] [RL9] [RL18]
			st_d.internal_data_error_flag = 1'b1;
		end
		if (flt.modulator_overrange_flag) begin // [RL10]
			st_d.modulator_overrange_flag = 1'b1;
		end
		if (flt.serial_out_mismatch_flag) begin // [RL12]
			st_d.serial_out_mismatch_flag = 1'b1;
		end
		if (flt.offset) begin // [RL13]
			st_d.offset = 1'b1;
		end
		if (init_done_i) begin // [RL11]
			st_d.initializing_flag = 1'b0;
		end
		if (st_q.initializing_flag) begin // [RL14]
			st_d.reset_occurred_flag = 1'b1;
		end
		offc_d = offcorr_stb_i ? offcorr_i : offc_q; // [RL16]
	end

	// Writes to status, counter and readback have no path into this state
	always_ff @(posedge clk_i or negedge rst_n) begin // [RL19]
		if (!rst_n) begin
			st_q   <= '{unused: 1'b0, internal_data_error_flag: 1'b0, modulator_overrange_flag: 1'b0, initializing_flag: 1'b1, serial_out_mismatch_flag: 1'b0,
				zero: 1'b0, offset: 1'b0, reset_occurred_flag: 1'b1}; // [RL11] [RL14]
			offc_q <= OFFCORR_RESET;
		end else if (ce_i) begin
			st_q   <= st_d;
			offc_q <= offc_d;
		end
	end

	// Read data, one cycle after the request
	logic [7:0] rdata_q, rdata_d;

	always_comb begin
		rdata_d = rdata_q;
		if (acc.rd) begin
			unique case (acc.addr)
				ADDR_THR_POS: rdata_d = thr_p_q;
				ADDR_THR_NEG: rdata_d = thr_n_q;
				ADDR_STATUS:  rdata_d = st_q; // [RL7]
				ADDR_COUNT:   rdata_d = count;
				ADDR_OFFCORR: rdata_d = offc_q;
				// Reserved and unmapped read zero; nothing is stored for them
				default:      rdata_d = ZERO_BYTE; // [RL17]
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= ZERO_BYTE;
		end else if (ce_i) begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o      = rdata_q;
	assign thr_pos_o    = thr_p_q;
	assign thr_neg_o    = thr_n_q;
	assign pos_arm_en_o = pos_en_q;
	assign neg_arm_en_o = neg_en_q;
	assign arm_pin_en_o = pin_en_q;
	assign arm_mode_o   = mode_q;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n);

	a_thr_locked: assert property ( // [RL1]
		ce_i && acc_wr_i && init_closed_bit_i && acc_addr_i == ADDR_THR_POS
		|=> $stable(thr_pos_o))
		else $error("positive threshold changed after lock");

	a_thr_written: assert property ( // [RL3]
		ce_i && acc_wr_i && !init_closed_bit_i && acc_addr_i == ADDR_THR_NEG
		|=> thr_neg_o == $past(acc_wdata_i))
		else $error("negative threshold write lost");

	a_one_zero: assert property ( // [RL4]
		thr_pos_o == 8'h00 && thr_neg_o != 8'h00
		|-> !pos_arm_en_o && neg_arm_en_o && arm_pin_en_o)
		else $error("single zero threshold handled wrongly");

	a_both_zero: assert property ( // [RL5]
		thr_pos_o == 8'h00 && thr_neg_o == 8'h00
		|-> !arm_pin_en_o && arm_mode_o == MODE_OFF)
		else $error("arming active with both thresholds zero");

	a_modulator_overrange_flag_clear: assert property ( // [RL10]
		ce_i && st_rd && !modulator_overrange_flag_i |=> !st_q.modulator_overrange_flag)
		else $error("over-range flag survived status read");

	a_modulator_overrange_flag_set: assert property ( // [RL6]
		ce_i && modulator_overrange_flag_i && st_rd |=> st_q.modulator_overrange_flag)
		else $error("over-range event lost in clearing read");

	a_init_hold: assert property ( // [RL11]
		ce_i && st_q.initializing_flag && !init_done_i |=> st_q.initializing_flag ##0 st_q.reset_occurred_flag)
		else $error("init flag dropped early");

	a_ide_persist: assert property ( // [RL9]
		ce_i && wcrc_err |=> st_q.internal_data_error_flag [*2])
		else $error("writable CRC fault not persistent");

	a_crc_flag: assert property ( // [RL8]
		ce_i && otp_crc_err_i |=> st_q.internal_data_error_flag)
		else $error("fault did not set error flag");

	a_status_ro: assert property ( // [RL19]
		ce_i && acc_wr_i && !acc_rd_i && acc_addr_i == ADDR_STATUS && st_q.serial_out_mismatch_flag
		|=> st_q.serial_out_mismatch_flag)
		else $error("status write changed a flag");

	a_cnt_step: assert property ( // [RL15]
		ce_i |=> count == $past(count) || count == $past(count) + 8'h01)
		else $error("counter jumped");

	a_offc_load: assert property ( // [RL16]
		ce_i && offcorr_stb_i && acc_rd_i && acc_addr_i == ADDR_OFFCORR
		##1 ce_i && acc_rd_i && acc_addr_i == ADDR_OFFCORR
		|=> rdata_o == $past(offcorr_i, 2))
		else $error("offset readback stale");

	a_serial_out_mismatch_flag_set: assert property ( // [RL12]
		ce_i && serial_out_mismatch_flag_i |=> st_q.serial_out_mismatch_flag)
		else $error("mismatch flag not set");

	a_offset_set: assert property ( // [RL13]
		ce_i && offset_lim_i |=> st_q.offset)
		else $error("offset flag not set");
endmodule : asrb_top
`default_nettype wire

// ### asrb_master_model.sv
`default_nettype none
module asrb_master_model
	import asrb_pkg::*;
(
	// Bus clock
	input  wire logic       clk_i,
	// Register access
	output logic            rd_o,
	output logic            wr_o,
	output logic      [4:0] addr_o,
	output logic      [7:0] wdata_o,
	input  wire logic [7:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 5'h00;
		wdata_o = 8'h00;
	end
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk_i);
		wr_o = 1'b1;
		addr_o = a;
		wdata_o = (a == ADDR_RSVD_A || a == ADDR_RSVD_B) ? ZERO_BYTE : d;
		@(negedge clk_i);
		wr_o = 1'b0;
		// Released data changes, so a stale byte is never mistaken for a write
		wdata_o = ~wdata_o;
	endtask : wr_reg
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
		@(negedge clk_i);
		rd_o = 1'b1;
		addr_o = a;
		@(negedge clk_i);
		rd_o = 1'b0;
		d = rdata_i;
		if (a == ADDR_STATUS) d[7] = 1'b0;
	endtask : rd_reg
endmodule : asrb_master_model
`default_nettype wire

// ### arming_status_register_bank_tb.sv
`default_nettype none
module arming_status_register_bank_tb;
	import asrb_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_i, rstn_i, ce_i, rd_s, wr, closed, done, otp, intf, stb;
	logic       pe, ne, pin;
	logic [1:0] mode, mode_o;
	logic [2:0] ev;
	logic [4:0] addr;
	logic [7:0] wdata, rdata, offc, tp, tn, d, c0, p, n;
	int         fail_count, checks_done, seed, i;

	asrb_top asrb_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .acc_rd_i(rd_s),
		.acc_wr_i(wr), .acc_addr_i(addr), .acc_wdata_i(wdata), .rdata_o(rdata),
		.init_closed_bit_i(closed), .init_done_i(done), .arm_mode_i(mode),
		.otp_crc_err_i(otp), .int_fault_i(intf), .modulator_overrange_flag_i(ev[2]), .serial_out_mismatch_flag_i(ev[1]),
		.offset_lim_i(ev[0]), .offcorr_stb_i(stb), .offcorr_i(offc), .thr_pos_o(tp),
		.thr_neg_o(tn), .pos_arm_en_o(pe), .neg_arm_en_o(ne), .arm_pin_en_o(pin),
		.arm_mode_o(mode_o));
	asrb_master_model asrb_master_model_i (.clk_i(clk_i), .rd_o(rd_s), .wr_o(wr),
		.addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));

	function automatic logic [7:0] stat_exp(input logic [2:0] e);
		return {2'b00, e[2], 1'b0, e[1], 1'b0, e[0], 1'b0};
	endfunction : stat_exp
	function automatic logic [7:0] arm_exp(input logic [7:0] a, b, input logic [1:0] m);
		return {3'b000, (a != 0 || b != 0) ? m : MODE_OFF, a != 0, b != 0, a != 0 || b != 0};
	endfunction : arm_exp

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		asrb_master_model_i.rd_reg(a, d);
		check(d, e);
	endtask : rd
	task automatic set_thr(input logic [7:0] a, b);
		asrb_master_model_i.wr_reg(ADDR_THR_POS, a);
		asrb_master_model_i.wr_reg(ADDR_THR_NEG, b);
	endtask : set_thr

	initial begin
		clk_i = 1'b0;
		forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
	end
	// Watchdog sized well above the few thousand cycles the sequence needs
	initial begin
		#(CLK_PERIOD_NS * 12000);
		fail_count++;
		end_of_test();
	end

	initial begin
		seed = 32'h11c3b83b;
		{rstn_i, closed, done, otp, intf, stb, ev, offc} = '0;
		ce_i = 1'b1;
		mode = 2'($random(seed)) | 2'h1;
		repeat (20) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge clk_i);
		check({tp, tn} == 16'h0000, 1'b1);
		check({5'h0, pe, ne, pin}, 8'h00);
		rd(ADDR_STATUS, 8'h11);
		rd(ADDR_STATUS, 8'h11);
		for (i = 0; i < 6; i++) begin
			p = (i == 1 || i == 3) ? 8'h00 : (i == 4 ? 8'hFF : 8'($random(seed)) | 8'h01);
			n = (i == 2 || i == 3) ? 8'h00 : (i == 4 ? 8'h01 : 8'($random(seed)) | 8'h01);
			set_thr(p, n);
			check({tp ^ p, tn ^ n} == 16'h0000, 1'b1);
			check({3'b000, mode_o, pe, ne, pin}, arm_exp(p, n, mode));
			rd(ADDR_THR_NEG, n);
		end
		@(negedge clk_i);
		done = 1'b1;
		@(negedge clk_i);
		done = 1'b0;
		rd(ADDR_STATUS, 8'h01);
		rd(ADDR_STATUS, 8'h00);
		closed = 1'b1;
		set_thr(8'h00, 8'h33);
		check({tp ^ p, tn ^ n} == 16'h0000, 1'b1);
		repeat (5) @(negedge clk_i);
		rd(ADDR_STATUS, 8'h00);
		for (i = 0; i < 3; i++) begin
			@(negedge clk_i);
			ev = 3'b100 >> i;
			@(negedge clk_i);
			ev = 3'b000;
			asrb_master_model_i.wr_reg(ADDR_STATUS, 8'h00);
			rd(ADDR_STATUS, stat_exp(3'b100 >> i));
			rd(ADDR_STATUS, 8'h00);
		end
		// An event while the enable is low must not be taken
		@(negedge clk_i);
		ce_i = 1'b0;
		ev = 3'b100;
		@(negedge clk_i);
		ev = 3'b000;
		ce_i = 1'b1;
		rd(ADDR_STATUS, 8'h00);
		@(negedge clk_i);
		intf = 1'b1;
		@(negedge clk_i);
		intf = 1'b0;
		rd(ADDR_STATUS, 8'h40);
		rd(ADDR_STATUS, 8'h00);
		otp = 1'b1;
		rd(ADDR_STATUS, 8'h40);
		rd(ADDR_STATUS, 8'h40);
		otp = 1'b0;
		asrb_master_model_i.rd_reg(ADDR_STATUS, d);
		rd(ADDR_STATUS, 8'h00);
		@(negedge clk_i);
		offc = 8'($random(seed));
		stb = 1'b1;
		@(negedge clk_i);
		stb = 1'b0;
		c0 = offc;
		offc = ~offc;
		asrb_master_model_i.wr_reg(ADDR_OFFCORR, 8'h5A);
		rd(ADDR_OFFCORR, c0);
		asrb_master_model_i.wr_reg(ADDR_RSVD_A, 8'hA5);
		rd(ADDR_RSVD_A, 8'h00);
		asrb_master_model_i.rd_reg(ADDR_COUNT, c0);
		asrb_master_model_i.wr_reg(ADDR_COUNT, 8'h00);
		repeat (TICK_CYCLES - 4) @(negedge clk_i);
		rd(ADDR_COUNT, c0 + 8'h01);
		end_of_test();
	end
endmodule : arming_status_register_bank_tb
`default_nettype wire
